// ---- lbps_sequencer.sv ----
// Purpose: rail sequencing, boost start-up supervision and setpoint registers
// Assumes: analog comparators and power-good flags arrive as asynchronous pins
// Notes: undervoltage resets every sequence state without ordered shutdown
`include "lbps_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lbps_sequencer #(
  parameter int DLY_STEP_CYC = `LBPS_DLY_STEP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vin_above_start,
  input wire logic vin_below_uvlo,
  input wire logic logic_supply_good,
  input wire logic interface_supply_good,
  input wire logic core_supply_good,
  input wire logic negative_pump_good,
  input wire logic boost_supply_good,
  input wire logic isolated_output_above_limit,
  input wire logic isolated_output_near_input,
  input wire logic isolated_output_dropped,
  input wire logic isolated_output_below_restart,
  input wire logic soft_start_reached,
  input wire logic boost_overvoltage,
  input wire logic gate_high_rail_short,
  input wire logic dynamic_gain_select,
  output logic panel_reset_n,
  output logic logic_buck_en,
  output logic interface_rail_en,
  output logic core_rail_en,
  output logic gate_low_rail_en,
  output logic boost_en,
  output logic half_source_rail_en,
  output logic gate_high_rail_en,
  output logic isolation_switch_limited,
  output logic isolation_switch_full,
  output logic boost_switching,
  output logic soft_start_discharge,
  output logic full_current_limit,
  output var lbps_pkg::lbps_gain_t common_gain,
  output logic [5:0] boost_setpoint,
  output logic [3:0] core_rail_setpoint,
  output logic [3:0] interface_rail_setpoint,
  output logic [3:0] gate_high_lt_setpoint,
  output logic [3:0] gate_high_ht_setpoint,
  output logic [5:0] gate_low_setpoint,
  output logic [53:0] gamma_outputs_code
);

  // ====
  // pin synchronisers
  logic [`LBPS_NPINS-1:0] pins_raw;
  logic [`LBPS_NPINS-1:0] pin_meta_ff;
  logic [`LBPS_NPINS-1:0] pin_ff;

  assign pins_raw = {dynamic_gain_select, gate_high_rail_short, boost_overvoltage, soft_start_reached,
                     isolated_output_below_restart, isolated_output_dropped, isolated_output_near_input,
                     isolated_output_above_limit, boost_supply_good, negative_pump_good, core_supply_good,
                     interface_supply_good, logic_supply_good, vin_below_uvlo, vin_above_start};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff <= '0;
      pin_ff <= '0;
    end else begin
      pin_meta_ff <= pins_raw;
      pin_ff <= pin_meta_ff;
    end
  end

  logic uvlo;
  assign uvlo = pin_ff[`LBPS_PIN_UVLO];

  // ====
  // register file
  logic [31:0] seq_cfg_ff;
  logic [31:0] boost_cfg_ff;
  logic [31:0] rail_cfg_ff;
  logic [31:0] gate_cfg_ff;
  logic [31:0] gma_hi_ff;
  logic [31:0] gma_lo_ff;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  function automatic logic known_addr(input logic [11:0] addr);
    return addr == `LBPS_ADDR_SEQ || addr == `LBPS_ADDR_BOOST || addr == `LBPS_ADDR_RAIL ||
           addr == `LBPS_ADDR_GATE || addr == `LBPS_ADDR_GMA_HI || addr == `LBPS_ADDR_GMA_LO ||
           addr == `LBPS_ADDR_STATUS;
  endfunction

  // ====
  // axi4-lite write channel
  logic aw_full_ff;
  logic w_full_ff;
  logic [11:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic do_write;
  logic [31:0] boost_merged;

  assign do_write = aw_full_ff && w_full_ff && !s_axi_bvalid;
  assign boost_merged = merge(boost_cfg_ff, w_data_ff, w_strb_ff, `LBPS_BOOST_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LBPS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known_addr(aw_addr_ff) ? `LBPS_RESP_OKAY : `LBPS_RESP_SLVERR;
      end
      // readies return after b: one write in flight
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // setpoints stand as written except boost code 63, clamped to 62; fixed constants are loaded as reset value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_cfg_ff <= `LBPS_SEQ_RST;
      boost_cfg_ff <= `LBPS_BOOST_RST;
      rail_cfg_ff <= `LBPS_RAIL_RST;
      gate_cfg_ff <= `LBPS_GATE_RST;
      gma_hi_ff <= `LBPS_GMA_RST;
      gma_lo_ff <= `LBPS_GMA_RST;
    end else if (do_write) begin
      case (aw_addr_ff)
        `LBPS_ADDR_SEQ: seq_cfg_ff <= merge(seq_cfg_ff, w_data_ff, w_strb_ff, `LBPS_SEQ_MASK);
        `LBPS_ADDR_BOOST: begin
          // code 63 exceeds 19 V: clamped
          boost_cfg_ff <= (boost_merged[5:0] > `LBPS_BOOST_MAX) ? {26'h0, `LBPS_BOOST_MAX}
                                                                : boost_merged;
        end
        `LBPS_ADDR_RAIL: rail_cfg_ff <= merge(rail_cfg_ff, w_data_ff, w_strb_ff, `LBPS_RAIL_MASK);
        `LBPS_ADDR_GATE: gate_cfg_ff <= merge(gate_cfg_ff, w_data_ff, w_strb_ff, `LBPS_GATE_MASK);
        `LBPS_ADDR_GMA_HI: gma_hi_ff <= merge(gma_hi_ff, w_data_ff, w_strb_ff, `LBPS_GMA_MASK);
        `LBPS_ADDR_GMA_LO: gma_lo_ff <= merge(gma_lo_ff, w_data_ff, w_strb_ff, `LBPS_GMA_MASK);
        default: ;
      endcase
    end
  end

  // no half-rail field exists; that buck follows the boost rail in analog
  assign boost_setpoint = boost_cfg_ff[5:0];
  assign core_rail_setpoint = rail_cfg_ff[3:0];
  assign interface_rail_setpoint = rail_cfg_ff[7:4];
  assign gate_high_lt_setpoint = gate_cfg_ff[3:0];
  assign gate_high_ht_setpoint = gate_cfg_ff[7:4];
  assign gate_low_setpoint = gate_cfg_ff[13:8];
  assign gamma_outputs_code = {gma_lo_ff[26:0], gma_hi_ff[26:0]};

  // ====
  // rail sequencer
  lbps_pkg::lbps_seq_t seq_ff;
  lbps_pkg::lbps_seq_t nxt_seq;
  logic [23:0] dly_cnt_ff;
  logic [2:0] dly_code;
  logic gate_ok;
  logic dly_done;

  function automatic logic [23:0] delay_cycles(input logic [2:0] code);
    return 24'(int'(code) * DLY_STEP_CYC);
  endfunction

  assign dly_done = dly_cnt_ff >= delay_cycles(dly_code);

  always_comb begin
    nxt_seq = seq_ff;
    gate_ok = 1'b0;
    dly_code = 3'h0;
    case (seq_ff)
      lbps_pkg::SEQ_OFF: begin
        if (pin_ff[`LBPS_PIN_START]) begin
          nxt_seq = lbps_pkg::SEQ_LOGIC;
        end
      end
      lbps_pkg::SEQ_LOGIC: begin
        if (pin_ff[`LBPS_PIN_LOGIC_GOOD] && pin_ff[`LBPS_PIN_IFACE_GOOD]) begin
          nxt_seq = lbps_pkg::SEQ_CORE;
        end
      end
      lbps_pkg::SEQ_CORE: begin
        gate_ok = pin_ff[`LBPS_PIN_CORE_GOOD];
        dly_code = seq_cfg_ff[`LBPS_SEQ_D1_LSB +: 3];
        if (gate_ok && dly_done) begin
          nxt_seq = lbps_pkg::SEQ_NEG;
        end
      end
      lbps_pkg::SEQ_NEG: begin
        gate_ok = pin_ff[`LBPS_PIN_NEG_GOOD];
        dly_code = seq_cfg_ff[`LBPS_SEQ_D2_LSB +: 3];
        if (gate_ok && dly_done) begin
          nxt_seq = lbps_pkg::SEQ_BOOST;
        end
      end
      lbps_pkg::SEQ_BOOST: begin
        gate_ok = pin_ff[`LBPS_PIN_BOOST_GOOD];
        dly_code = seq_cfg_ff[`LBPS_SEQ_D3_LSB +: 3];
        if (gate_ok && dly_done) begin
          nxt_seq = lbps_pkg::SEQ_RUN;
        end
      end
      lbps_pkg::SEQ_RUN: nxt_seq = lbps_pkg::SEQ_RUN;
      default: nxt_seq = lbps_pkg::SEQ_OFF;
    endcase
    if (uvlo) begin
      nxt_seq = lbps_pkg::SEQ_OFF;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_ff <= lbps_pkg::SEQ_OFF;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // a good dropout restarts the count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_cnt_ff <= 24'h00_0000;
    end else if (uvlo || nxt_seq != seq_ff || !gate_ok) begin
      dly_cnt_ff <= 24'h00_0000;
    end else if (!dly_done) begin
      dly_cnt_ff <= dly_cnt_ff + 24'h00_0001;
    end
  end

  // enable vector: logic, interface, core, gate low, boost, half, gate high, reset release
  function automatic logic [7:0] rail_vector(input lbps_pkg::lbps_seq_t st);
    case (st)
      lbps_pkg::SEQ_LOGIC: return 8'h03;
      lbps_pkg::SEQ_CORE: return 8'h07;
      lbps_pkg::SEQ_NEG: return 8'h8f;
      lbps_pkg::SEQ_BOOST: return 8'hbf;
      lbps_pkg::SEQ_RUN: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

  logic [7:0] nxt_rails;
  assign nxt_rails = rail_vector(nxt_seq);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      logic_buck_en <= 1'b0;
      interface_rail_en <= 1'b0;
      core_rail_en <= 1'b0;
      gate_low_rail_en <= 1'b0;
      boost_en <= 1'b0;
      half_source_rail_en <= 1'b0;
      gate_high_rail_en <= 1'b0;
      panel_reset_n <= 1'b0;
    end else begin
      logic_buck_en <= nxt_rails[0];
      interface_rail_en <= nxt_rails[1];
      core_rail_en <= nxt_rails[2];
      gate_low_rail_en <= nxt_rails[3];
      boost_en <= nxt_rails[4];
      half_source_rail_en <= nxt_rails[5];
      gate_high_rail_en <= nxt_rails[6];
      panel_reset_n <= nxt_rails[7];
    end
  end

  // ====
  // boost start-up and protection
  lbps_pkg::lbps_boost_t bst_ff;
  lbps_pkg::lbps_boost_t nxt_bst;
  logic ss_done_ff;
  logic nxt_ss_done;

  always_comb begin
    nxt_bst = bst_ff;
    case (bst_ff)
      lbps_pkg::BST_IDLE: begin
        if (boost_en) begin
          nxt_bst = lbps_pkg::BST_LIMIT;
        end
      end
      lbps_pkg::BST_LIMIT: begin
        if (pin_ff[`LBPS_PIN_ISO_NEAR]) begin
          nxt_bst = lbps_pkg::BST_FULL;
        end
      end
      lbps_pkg::BST_FULL: begin
        if (pin_ff[`LBPS_PIN_ISO_DROP]) begin
          nxt_bst = lbps_pkg::BST_FAULT;
        end
      end
      lbps_pkg::BST_FAULT: begin
        if (pin_ff[`LBPS_PIN_ISO_LOW]) begin
          nxt_bst = lbps_pkg::BST_LIMIT;
        end
      end
      default: nxt_bst = lbps_pkg::BST_IDLE;
    endcase
    if (!boost_en || uvlo) begin
      nxt_bst = lbps_pkg::BST_IDLE;
    end
  end

  // ss completion held while in full
  assign nxt_ss_done = (nxt_bst == lbps_pkg::BST_FULL) &&
                       (ss_done_ff || pin_ff[`LBPS_PIN_SS_DONE] || pin_ff[`LBPS_PIN_BOOST_GOOD]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bst_ff <= lbps_pkg::BST_IDLE;
      ss_done_ff <= 1'b0;
      isolation_switch_limited <= 1'b0;
      isolation_switch_full <= 1'b0;
      boost_switching <= 1'b0;
      soft_start_discharge <= 1'b1;
      full_current_limit <= 1'b0;
    end else begin
      bst_ff <= nxt_bst;
      ss_done_ff <= nxt_ss_done;
      // limited below the short threshold
      isolation_switch_limited <= (nxt_bst == lbps_pkg::BST_LIMIT) && !pin_ff[`LBPS_PIN_ISO_ABOVE];
      isolation_switch_full <= nxt_bst == lbps_pkg::BST_FULL;
      // ovp and pump short gate switching, unlatched
      boost_switching <= (nxt_bst == lbps_pkg::BST_FULL) && !pin_ff[`LBPS_PIN_OVP] &&
                         !pin_ff[`LBPS_PIN_GH_SHORT];
      soft_start_discharge <= uvlo || nxt_bst != lbps_pkg::BST_FULL;
      full_current_limit <= nxt_ss_done;
    end
  end

  // ====
  // common-voltage gain
  function automatic lbps_pkg::lbps_gain_t gain_select(input logic dyn_mode, input logic dyn_pin,
                                                       input logic [1:0] fixed);
    if (dyn_mode) begin
      return dyn_pin ? lbps_pkg::GAIN_NEG2 : lbps_pkg::GAIN_NEG4;
    end
    case (fixed)
      2'h0: return lbps_pkg::GAIN_BUF;
      2'h1: return lbps_pkg::GAIN_NEG1;
      2'h2: return lbps_pkg::GAIN_NEG2;
      default: return lbps_pkg::GAIN_NEG3;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      common_gain <= lbps_pkg::GAIN_BUF;
    end else begin
      common_gain <= gain_select(seq_cfg_ff[`LBPS_SEQ_DYNMODE_BIT], pin_ff[`LBPS_PIN_DYN],
                                 seq_cfg_ff[`LBPS_SEQ_FIXG_LSB +: 2]);
    end
  end

  // ====
  // axi4-lite read channel
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign status_word = {6'h00, full_current_limit, boost_switching, isolation_switch_full,
                        isolation_switch_limited, panel_reset_n, 2'(bst_ff), 3'(seq_ff), 1'b0, pin_ff};

  always_comb begin
    case (s_axi_araddr)
      `LBPS_ADDR_SEQ: rd_mux = seq_cfg_ff;
      `LBPS_ADDR_BOOST: rd_mux = boost_cfg_ff;
      `LBPS_ADDR_RAIL: rd_mux = rail_cfg_ff;
      `LBPS_ADDR_GATE: rd_mux = gate_cfg_ff;
      `LBPS_ADDR_GMA_HI: rd_mux = gma_hi_ff;
      `LBPS_ADDR_GMA_LO: rd_mux = gma_lo_ff;
      `LBPS_ADDR_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LBPS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= known_addr(s_axi_araddr) ? `LBPS_RESP_OKAY : `LBPS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- lbps_consts.svh ----
// Purpose: constants of the lcd bias power sequencer
// Assumes: 40 MHz aclk, 32-bit axi4-lite register bus
// Notes: offsets are byte addresses
`ifndef LBPS_CONSTS_SVH
`define LBPS_CONSTS_SVH

// ====
// timing
`define LBPS_CLK_KHZ 40000
`define LBPS_DLY_STEP_MS 5
`define LBPS_DLY_STEP_CYC (`LBPS_DLY_STEP_MS * `LBPS_CLK_KHZ)

// ====
// register offsets
`define LBPS_ADDR_SEQ 12'h000
`define LBPS_ADDR_BOOST 12'h004
`define LBPS_ADDR_RAIL 12'h008
`define LBPS_ADDR_GATE 12'h00c
`define LBPS_ADDR_GMA_HI 12'h010
`define LBPS_ADDR_GMA_LO 12'h014
`define LBPS_ADDR_STATUS 12'h018

// ====
// writable masks and reset values
`define LBPS_SEQ_MASK 32'h0001_3777
`define LBPS_BOOST_MASK 32'h0000_003f
`define LBPS_RAIL_MASK 32'h0000_00ff
`define LBPS_GATE_MASK 32'h0000_3fff
`define LBPS_GMA_MASK 32'h07ff_ffff
`define LBPS_SEQ_RST 32'h0000_0111
`define LBPS_BOOST_RST 32'h0000_0020
`define LBPS_RAIL_RST 32'h0000_0033
`define LBPS_GATE_RST 32'h0000_1f77
`define LBPS_GMA_RST 32'h0000_0000
`define LBPS_BOOST_MAX 6'h3e

// ====
// field positions
`define LBPS_SEQ_D1_LSB 0
`define LBPS_SEQ_D2_LSB 4
`define LBPS_SEQ_D3_LSB 8
`define LBPS_SEQ_FIXG_LSB 12
`define LBPS_SEQ_DYNMODE_BIT 16

// ====
// synchronised pin indices
`define LBPS_PIN_START 0
`define LBPS_PIN_UVLO 1
`define LBPS_PIN_LOGIC_GOOD 2
`define LBPS_PIN_IFACE_GOOD 3
`define LBPS_PIN_CORE_GOOD 4
`define LBPS_PIN_NEG_GOOD 5
`define LBPS_PIN_BOOST_GOOD 6
`define LBPS_PIN_ISO_ABOVE 7
`define LBPS_PIN_ISO_NEAR 8
`define LBPS_PIN_ISO_DROP 9
`define LBPS_PIN_ISO_LOW 10
`define LBPS_PIN_SS_DONE 11
`define LBPS_PIN_OVP 12
`define LBPS_PIN_GH_SHORT 13
`define LBPS_PIN_DYN 14
`define LBPS_NPINS 15

`define LBPS_RESP_OKAY 2'h0
`define LBPS_RESP_SLVERR 2'h2
`endif

// ---- lbps_pkg.sv ----
// Purpose: types of the lcd bias power sequencer
// Assumes: nothing
// Notes: constants live in lbps_consts.svh
`default_nettype none
package lbps_pkg;
  // ====
  // state and mode types
  typedef enum logic [2:0] {SEQ_OFF, SEQ_LOGIC, SEQ_CORE, SEQ_NEG, SEQ_BOOST, SEQ_RUN} lbps_seq_t;
  typedef enum logic [1:0] {BST_IDLE, BST_LIMIT, BST_FULL, BST_FAULT} lbps_boost_t;
  typedef enum logic [2:0] {GAIN_BUF, GAIN_NEG1, GAIN_NEG2, GAIN_NEG3, GAIN_NEG4} lbps_gain_t;
endpackage
`default_nettype wire

// ---- lbps_seq_properties.sv ----
// Purpose: concurrent checks on the sequencer ports
// Assumes: pins reach outputs 3 edges after they settle
// Notes: held conditions use 5 edges to clear the synchronisers
`timescale 1ns/1ps
`default_nettype none
module lbps_seq_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic vin_below_uvlo,
  input wire logic logic_supply_good,
  input wire logic interface_supply_good,
  input wire logic core_supply_good,
  input wire logic negative_pump_good,
  input wire logic boost_supply_good,
  input wire logic isolated_output_dropped,
  input wire logic boost_overvoltage,
  input wire logic gate_high_rail_short,
  input wire logic panel_reset_n,
  input wire logic logic_buck_en,
  input wire logic interface_rail_en,
  input wire logic core_rail_en,
  input wire logic gate_low_rail_en,
  input wire logic boost_en,
  input wire logic half_source_rail_en,
  input wire logic gate_high_rail_en,
  input wire logic isolation_switch_full,
  input wire logic boost_switching,
  input wire logic soft_start_discharge
);
  // ====
  // sequences
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_uvlo_held;
    vin_below_uvlo[*5];
  endsequence
  sequence s_stall;
    (boost_overvoltage || gate_high_rail_short)[*5];
  endsequence
  // ====
  // assertions
  chk_logic_first: assert property (
    $rose(logic_buck_en) |-> interface_rail_en && !panel_reset_n)
    else $error("logic start order");
  chk_core_gated: assert property (
    $rose(core_rail_en) |-> $past(logic_supply_good, 3) && $past(interface_supply_good, 3))
    else $error("core start early");
  chk_reset_release: assert property (
    $rose(panel_reset_n) |-> gate_low_rail_en && $past(core_supply_good, 3))
    else $error("reset release order");
  chk_boost_pair: assert property (
    $rose(boost_en) |-> half_source_rail_en && $past(negative_pump_good, 3))
    else $error("boost start order");
  chk_gate_high: assert property (
    $rose(gate_high_rail_en) |-> boost_en && $past(boost_supply_good, 3))
    else $error("gate high early");
  chk_uvlo_off: assert property (
    s_uvlo_held |-> !(logic_buck_en || interface_rail_en || core_rail_en || gate_low_rail_en
      || boost_en || half_source_rail_en || gate_high_rail_en) && soft_start_discharge)
    else $error("rail on in uvlo");
  chk_stall_stop: assert property (
    s_stall |-> !boost_switching)
    else $error("switching in stall");
  chk_iso_first: assert property (
    $rose(boost_switching) |-> isolation_switch_full)
    else $error("switching before iso full");
  chk_drop_off: assert property (
    isolated_output_dropped[*5] |-> !isolation_switch_full && !boost_switching)
    else $error("running after drop");
endmodule
bind lbps_sequencer lbps_seq_properties i_props (.*);
`default_nettype wire

// ---- lbps_rail_model.sv ----
// Purpose: rail converters answering the enables with power good
// Assumes: each rail settles PG_DLY cycles after enable
// Notes: larger PG_DLY models a slow rail
`timescale 1ns/1ps
`default_nettype none
module lbps_rail_model #(
  parameter int PG_DLY = 4
) (
  input wire logic aclk,
  input wire logic logic_buck_en,
  input wire logic interface_rail_en,
  input wire logic core_rail_en,
  input wire logic gate_low_rail_en,
  input wire logic boost_en,
  output logic logic_supply_good,
  output logic interface_supply_good,
  output logic core_supply_good,
  output logic negative_pump_good,
  output logic boost_supply_good
);
  logic [4:0] en;
  logic [7:0] cnt_ff [5];
  assign en = {boost_en, gate_low_rail_en, core_rail_en, interface_rail_en, logic_buck_en};
  // ====
  // rails discharge when disabled, so good drops at the first edge after enable falls
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 5; i++) begin
      if (!en[i]) begin
        cnt_ff[i] <= 8'h00;
      end else if (cnt_ff[i] != 8'(PG_DLY)) begin
        cnt_ff[i] <= cnt_ff[i] + 8'h01;
      end
    end
  end
  assign logic_supply_good = cnt_ff[0] == 8'(PG_DLY);
  assign interface_supply_good = cnt_ff[1] == 8'(PG_DLY);
  assign core_supply_good = cnt_ff[2] == 8'(PG_DLY);
  assign negative_pump_good = cnt_ff[3] == 8'(PG_DLY);
  assign boost_supply_good = cnt_ff[4] == 8'(PG_DLY);
endmodule
`default_nettype wire

// ---- lcd_bias_power_sequencer_test.sv ----
// Purpose: self-checking bench of the sequencer
// Assumes: rail model closes the power-good loop
// Notes: a 10-cycle delay step keeps the run short
`include "lbps_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module lcd_bias_power_sequencer_test;
  localparam int STEP = 10;
  localparam int PG = 4;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic vin_above_start, vin_below_uvlo, logic_supply_good, interface_supply_good, core_supply_good;
  logic negative_pump_good, boost_supply_good, isolated_output_above_limit, isolated_output_near_input;
  logic isolated_output_dropped, isolated_output_below_restart, soft_start_reached, boost_overvoltage;
  logic gate_high_rail_short, dynamic_gain_select, panel_reset_n, logic_buck_en, interface_rail_en;
  logic core_rail_en, gate_low_rail_en, boost_en, half_source_rail_en, gate_high_rail_en;
  logic isolation_switch_limited, isolation_switch_full, boost_switching, soft_start_discharge;
  logic full_current_limit;
  lbps_pkg::lbps_gain_t common_gain;
  logic [5:0] boost_setpoint, gate_low_setpoint;
  logic [3:0] core_rail_setpoint, interface_rail_setpoint, gate_high_lt_setpoint, gate_high_ht_setpoint;
  logic [53:0] gamma_outputs_code;
  logic [31:0] d;
  logic [1:0] r;
  int fails, n_tests, cyc;
  lbps_sequencer #(.DLY_STEP_CYC(STEP)) i_dut (.*);
  lbps_rail_model #(.PG_DLY(PG)) i_rails (.*);
  // ====
  // helpers
  task automatic ck(input logic [63:0] g, input logic [63:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 0;
      end
    end while (s_axi_bvalid !== 1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 0;
      end
    end while (s_axi_rvalid !== 1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // rise within lo..lo+6 cycles
  task automatic span(ref logic s, input int lo);
    int n = 0;
    while (s !== 1) begin
      @(posedge aclk);
      n++;
    end
    ck(n >= lo && n <= lo + 6, 1, "delay");
  endtask
  task automatic test_done();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ====
  // scenarios
  task automatic regs();
    logic [11:0] ad [4] = '{`LBPS_ADDR_SEQ, `LBPS_ADDR_BOOST, `LBPS_ADDR_RAIL, `LBPS_ADDR_GATE};
    logic [31:0] rv [4] = '{`LBPS_SEQ_RST, `LBPS_BOOST_RST, `LBPS_RAIL_RST, `LBPS_GATE_RST};
    for (int i = 0; i < 4; i++) begin
      rd(ad[i]);
      ck(d, rv[i], "reset value");
    end
    rd(12'h01c);
    ck({r, d}, {`LBPS_RESP_SLVERR, 32'h0000_0000}, "unmapped read");
    wr(12'h01c, 32'h0000_0001);
    ck(r, `LBPS_RESP_SLVERR, "unmapped write");
    wr(`LBPS_ADDR_BOOST, 32'h0000_003f);
    rd(`LBPS_ADDR_BOOST);
    ck({d, 26'h000_0000, boost_setpoint}, {32'h0000_003e, 32'h0000_003e}, "boost clamp");
    wr(`LBPS_ADDR_RAIL, 32'h0000_005a);
    ck({interface_rail_setpoint, core_rail_setpoint}, 8'h5a, "buck codes");
    wr(`LBPS_ADDR_GATE, 32'h0000_2af0);
    ck({gate_high_ht_setpoint, gate_high_lt_setpoint}, 8'hf0, "pump codes");
    ck(gate_low_setpoint, 6'h2a, "gl code");
    wr(`LBPS_ADDR_GMA_LO, 32'hffff_ffff);
    rd(`LBPS_ADDR_GMA_LO);
    ck(d, 32'h07ff_ffff, "gamma width");
    ck(gamma_outputs_code[53:27], 27'h7ff_ffff, "gamma port");
  endtask
  task automatic gains();
    for (int k = 0; k < 4; k++) begin
      wr(`LBPS_ADDR_SEQ, 32'h0000_0701 | (k << 12));
      st(2);
      ck(common_gain, k, "fixed gain");
    end
    wr(`LBPS_ADDR_SEQ, 32'h0001_0701);
    for (int k = 0; k < 2; k++) begin
      dynamic_gain_select <= k[0];
      st(5);
      ck(common_gain, k ? lbps_pkg::GAIN_NEG2 : lbps_pkg::GAIN_NEG4, "dynamic gain");
    end
    wr(`LBPS_ADDR_SEQ, 32'h0000_0701);
  endtask
  task automatic power_up();
    vin_above_start <= 1;
    span(logic_buck_en, 2);
    ck({interface_rail_en, panel_reset_n, core_rail_en}, 3'b100, "logic start");
    span(core_rail_en, PG);
    span(panel_reset_n, STEP + PG);
    ck(gate_low_rail_en, 1, "gl start");
    span(boost_en, PG);
    ck(half_source_rail_en, 1, "half start");
    span(gate_high_rail_en, 7 * STEP + PG);
  endtask
  task automatic boost();
    ck(isolation_switch_limited, 1, "limited start");
    isolated_output_above_limit <= 1;
    isolated_output_near_input <= 1;
    soft_start_reached <= 1;
    st(5);
    ck({isolation_switch_full, boost_switching, soft_start_discharge, full_current_limit}, 4'b1101, "full on");
    boost_overvoltage <= 1;
    st(5);
    ck(boost_switching, 0, "ovp stop");
    boost_overvoltage <= 0;
    gate_high_rail_short <= 1;
    st(5);
    ck(boost_switching, 0, "short stop");
    gate_high_rail_short <= 0;
    st(5);
    ck(boost_switching, 1, "resume");
    isolated_output_dropped <= 1;
    st(5);
    ck({isolation_switch_full, boost_switching, soft_start_discharge}, 3'b001, "drop");
    {isolated_output_dropped, isolated_output_near_input, isolated_output_above_limit} <= 3'b000;
    isolated_output_below_restart <= 1;
    st(5);
    ck(isolation_switch_limited, 1, "restart");
  endtask
  task automatic uvlo_off();
    vin_below_uvlo <= 1;
    st(5);
    ck({logic_buck_en, interface_rail_en, core_rail_en, gate_low_rail_en, boost_en, half_source_rail_en,
      gate_high_rail_en, panel_reset_n}, 0, "rails off");
    ck(soft_start_discharge, 1, "ss discharge");
  endtask
  // ====
  // clock, timeout and main sequence
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr} = '0;
    {s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, vin_above_start, vin_below_uvlo} = '0;
    {isolated_output_above_limit, isolated_output_near_input, isolated_output_dropped} = '0;
    {isolated_output_below_restart, soft_start_reached, boost_overvoltage} = '0;
    {gate_high_rail_short, dynamic_gain_select} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    regs();
    gains();
    power_up();
    boost();
    uvlo_off();
    test_done();
  end
endmodule
`default_nettype wire
